// >>> mqwp_regs.svh
// Purpose: Constants for the multi-queue write port.
// Assumes: Included by bare name before the package.
// Notes:   Field positions refer to the 8-bit write queue address.
`ifndef MQWP_REGS_SVH
`define MQWP_REGS_SVH
`define MQWP_ADDR_W      8
`define MQWP_QSEL_MSB    4
`define MQWP_DEV_LSB     5
`define MQWP_DEV_MSB     7
`define MQWP_QUAD_MSB    1
`define MQWP_GROUP_W     8
`define MQWP_RST_QUEUE   5'h00
`define MQWP_RST_QUAD    2'h0
`define MQWP_GRP_LAST    2'h3
`endif

// >>> mqwp_pkg.sv
// Purpose: Types and shared decode for the multi-queue write port.
// Assumes: Address layout as in mqwp_regs.svh.
// Notes:   Flag mode selects strobed quadrant or polled stepping.
`include "mqwp_regs.svh"
package mqwp_pkg;
  typedef logic [`MQWP_ADDR_W-1:0] mqwp_addr_t;
  typedef logic [`MQWP_QSEL_MSB:0] mqwp_queue_t;
  typedef logic [`MQWP_DEV_MSB-`MQWP_DEV_LSB:0] mqwp_dev_t;
  typedef logic [`MQWP_QUAD_MSB:0] mqwp_quad_t;
  typedef enum logic [0:0] {
    MQWP_DIRECT = 1'b0,
    MQWP_POLLED = 1'b1
  } mqwp_flag_mode_t;

  // The top three address bits name the device in an expanded array.
  function automatic logic mqwp_dev_match(input mqwp_addr_t a,
                                          input mqwp_dev_t  id);
    mqwp_dev_match = (a[`MQWP_DEV_MSB:`MQWP_DEV_LSB] == id);
  endfunction : mqwp_dev_match
endpackage : mqwp_pkg

// >>> mqwp_flag_bus.sv
// Purpose: Almost-full status bus, quadrant select and frame sync.
// Assumes: Queue almost-full inputs are already on the write clock.
// Notes:   The bus shows one group of eight queues, active low.
`timescale 1ns/100ps
`include "mqwp_regs.svh"
module mqwp_flag_bus (
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire mqwp_pkg::mqwp_flag_mode_t i_flag_mode,
  input  wire logic                     i_flag_quadrant_strobe,
  input  wire mqwp_pkg::mqwp_addr_t     i_write_queue_address,
  input  wire mqwp_pkg::mqwp_dev_t      i_device_id,
  input  wire logic [31:0]              i_queue_almost_full,
  output logic [`MQWP_GROUP_W-1:0]      o_almost_full_status_bus_n,
  output logic                          o_status_frame_sync,
  output mqwp_pkg::mqwp_quad_t          o_quadrant
);
  import mqwp_pkg::*;

  typedef struct packed {
    mqwp_quad_t               quad;
    mqwp_quad_t               grp;
    logic [`MQWP_GROUP_W-1:0] bus_n;
    logic                     sync;
  } mqwp_fb_state_t;

  mqwp_fb_state_t st_r;
  mqwp_fb_state_t st_nxt;

  // Quadrant is taken only on a strobe naming this device; bits 4:2 unused.
  // The group counter steps every edge in polled mode, no write needed.
  always_comb begin
    mqwp_quad_t sel;
    sel    = '0;
    st_nxt = st_r;
    if (i_flag_mode == MQWP_DIRECT && i_flag_quadrant_strobe &&
        mqwp_dev_match(i_write_queue_address, i_device_id)) begin
      st_nxt.quad = i_write_queue_address[`MQWP_QUAD_MSB:0];
    end
    if (i_flag_mode == MQWP_POLLED) begin
      sel         = st_r.grp;
      st_nxt.grp  = st_r.grp + 2'h1;
      st_nxt.sync = (st_r.grp == `MQWP_RST_QUAD);
    end else begin
      sel         = st_nxt.quad;
      st_nxt.grp  = `MQWP_RST_QUAD;
      st_nxt.sync = 1'b0;
    end
    st_nxt.bus_n = ~i_queue_almost_full[{sel, 3'h0} +: `MQWP_GROUP_W];
  end

  // All status outputs leave from flops on the write clock.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '{quad: `MQWP_RST_QUAD, grp: `MQWP_RST_QUAD,
                bus_n: '1, sync: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_almost_full_status_bus_n = st_r.bus_n;
  assign o_status_frame_sync        = st_r.sync;
  assign o_quadrant                 = st_r.quad;

  quad_take_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_flag_mode == MQWP_DIRECT && i_flag_quadrant_strobe &&
     mqwp_dev_match(i_write_queue_address, i_device_id))
    |=> o_quadrant == $past(i_write_queue_address[1:0]))
    else $error("Quadrant not taken from the strobed address.");

  frame_sync_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_flag_mode == MQWP_POLLED && o_status_frame_sync)[*1] ##1
    (i_flag_mode == MQWP_POLLED)[*3] |=> o_status_frame_sync)
    else $error("Frame sync does not repeat every four groups.");
endmodule : mqwp_flag_bus

// >>> mqwp_write_port.sv
// Purpose: Write-port queue selection and write steering.
// Assumes: One free-running write clock; inputs synchronous to it.
// Notes:   A new queue takes writes from the second edge after selection.
//
// Functional notes
// - Take address only when select strobe high.
// - Enabled edge stores data into current queue.
// - Selection ignores the write enable level.
// - New queue written from second edge on.
// - Selection edge and next use old queue.
// - Low five address bits pick queue.
// - Top three bits must match device ID.
// - Quadrant strobe takes bits 1:0, ID-gated.
// - Quadrant and polling need no write enable.
// - Polled bus steps groups, sync on clock.
// - Status and flags change only on clock.
// - Expansion token timed by the write clock.
`timescale 1ns/100ps
`include "mqwp_regs.svh"
module mqwp_write_port #(
  parameter int DATA_W = 36
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_write_queue_select_strobe,
  input  wire mqwp_pkg::mqwp_addr_t     i_write_queue_address,
  input  wire logic                     i_write_en_n,
  input  wire logic [DATA_W-1:0]        i_write_data,
  input  wire logic                     i_flag_quadrant_strobe,
  input  wire mqwp_pkg::mqwp_flag_mode_t i_flag_mode,
  input  wire mqwp_pkg::mqwp_dev_t      i_device_id,
  input  wire logic [31:0]              i_queue_almost_full,
  input  wire logic [31:0]              i_queue_full,
  input  wire logic                     i_expansion_token_in,
  output logic                          o_wr_valid,
  output mqwp_pkg::mqwp_queue_t         o_wr_queue,
  output logic [DATA_W-1:0]             o_wr_data,
  output mqwp_pkg::mqwp_queue_t         o_current_queue,
  output logic                          o_device_owns_write,
  output logic [`MQWP_GROUP_W-1:0]      o_almost_full_status_bus_n,
  output logic                          o_status_frame_sync,
  output mqwp_pkg::mqwp_quad_t          o_quadrant,
  output logic                          o_almost_full_flag_n,
  output logic                          o_full_flag_n,
  output logic                          o_expansion_token_out,
  output logic                          o_peer_token_seen
);
  import mqwp_pkg::*;

  typedef struct packed {
    logic              pend_vld;
    mqwp_queue_t       pend_q;
    logic              pend_own;
    mqwp_queue_t       act_q;
    logic              own;
    logic              wr_vld;
    mqwp_queue_t       wr_q;
    logic [DATA_W-1:0] wr_d;
    logic              af_n;
    logic              ff_n;
    logic              tok_out;
    logic              tok_in;
  } mqwp_wp_state_t;

  mqwp_wp_state_t st_r;
  mqwp_wp_state_t st_nxt;
  logic           sel_take;

  // A strobed edge always reloads ownership from the ID match: a foreign ID means
  // another device in the array now takes the writes.
  assign sel_take = i_write_queue_select_strobe;

  // Two-stage select: the pending stage is loaded on the strobed edge and
  // promoted one edge later, so the selection edge and the one after it
  // still write to the old queue. Writes never wait for the enable to
  // select, which keeps queue changes free of dead data cycles.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.pend_vld = sel_take;
    if (sel_take) begin
      st_nxt.pend_q   = i_write_queue_address[`MQWP_QSEL_MSB:0];
      st_nxt.pend_own = mqwp_dev_match(i_write_queue_address,
                                       i_device_id);
    end
    if (st_r.pend_vld) begin
      st_nxt.act_q = st_r.pend_q;
      st_nxt.own   = st_r.pend_own;
    end
    st_nxt.wr_vld = !i_write_en_n && st_r.own;
    st_nxt.wr_q   = st_r.act_q;
    st_nxt.wr_d   = i_write_data;
    st_nxt.af_n   = ~i_queue_almost_full[st_r.act_q];
    st_nxt.ff_n   = ~i_queue_full[st_r.act_q];
    st_nxt.tok_out = st_r.own;
    st_nxt.tok_in  = i_expansion_token_in;
  end

  // Single state register; the device owns nothing until first selected.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '{pend_vld: 1'b0, pend_q: `MQWP_RST_QUEUE, pend_own: 1'b0,
                act_q: `MQWP_RST_QUEUE, own: 1'b0, wr_vld: 1'b0,
                wr_q: `MQWP_RST_QUEUE, wr_d: '0, af_n: 1'b1,
                ff_n: 1'b1, tok_out: 1'b0, tok_in: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_wr_valid            = st_r.wr_vld;
  assign o_wr_queue            = st_r.wr_q;
  assign o_wr_data             = st_r.wr_d;
  assign o_current_queue       = st_r.act_q;
  assign o_device_owns_write   = st_r.own;
  assign o_almost_full_flag_n  = st_r.af_n;
  assign o_full_flag_n         = st_r.ff_n;
  assign o_expansion_token_out = st_r.tok_out;
  assign o_peer_token_seen     = st_r.tok_in;

  // Flag quadrant and polled stepping live in their own block.
  mqwp_flag_bus u_flag_bus (
    .i_clk                      (i_clk),
    .i_arst_n                   (i_arst_n),
    .i_flag_mode                (i_flag_mode),
    .i_flag_quadrant_strobe     (i_flag_quadrant_strobe),
    .i_write_queue_address      (i_write_queue_address),
    .i_device_id                (i_device_id),
    .i_queue_almost_full        (i_queue_almost_full),
    .o_almost_full_status_bus_n (o_almost_full_status_bus_n),
    .o_status_frame_sync        (o_status_frame_sync),
    .o_quadrant                 (o_quadrant)
  );

  sequence s_local_sel;
    i_write_queue_select_strobe &&
    mqwp_dev_match(i_write_queue_address, i_device_id);
  endsequence

  sequence s_foreign_sel;
    i_write_queue_select_strobe &&
    !mqwp_dev_match(i_write_queue_address, i_device_id);
  endsequence

  new_queue_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    s_local_sel |-> ##2
      (o_current_queue == $past(i_write_queue_address[4:0], 2) &&
       o_device_owns_write))
    else $error("New queue not active two edges after selection.");

  // A strobe on the edge before may legally promote its own queue here,
  // so only a fresh selection must leave the current queue alone.
  old_queue_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_write_queue_select_strobe && !$past(i_write_queue_select_strobe)) |=>
    $stable(o_current_queue))
    else $error("Queue changed on the edge after selection.");

  write_store_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (!i_write_en_n && o_device_owns_write) |=>
    (o_wr_valid && o_wr_queue == $past(o_current_queue) &&
     o_wr_data == $past(i_write_data)))
    else $error("Enabled write not stored to current queue.");

  no_write_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_write_en_n || !o_device_owns_write) |=> !o_wr_valid)
    else $error("Write issued without enable or ownership.");

  foreign_dev_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    s_foreign_sel ##1 !i_write_queue_select_strobe |=> !o_device_owns_write)
    else $error("Device kept ownership after foreign selection.");

  hold_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (!i_write_queue_select_strobe)[*2] |=> $stable(o_current_queue))
    else $error("Queue changed without a strobed selection.");

  full_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    1'b1 |=> o_full_flag_n == !$past(i_queue_full[o_current_queue]))
    else $error("Full flag does not follow the current queue.");

  token_out_a: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    s_local_sel ##2 1'b1 |=> o_expansion_token_out)
    else $error("Token output not raised after ownership.");
endmodule : mqwp_write_port

// >>> mqwp_writer.sv
// Purpose: Behavioural writer facing the write port.
// Assumes: Requests change just after a rising clock edge.
// Notes:   Selection strobe is held off until configuration is done.
`timescale 1ns/100ps
module mqwp_writer #(
  parameter int DATA_W = 36
) (
  input  wire logic            i_clk,
  input  wire logic            i_serial_config_done_n,
  output mqwp_pkg::mqwp_addr_t o_addr,
  output logic                 o_sel,
  output logic                 o_quad,
  output logic                 o_wen_n,
  output logic [DATA_W-1:0]    o_data
);
  import mqwp_pkg::*;

  // Idle request at time zero: no strobe and no write.
  initial begin
    o_addr  = 8'h00;
    o_sel   = 1'b0;
    o_quad  = 1'b0;
    o_wen_n = 1'b1;
    o_data  = '0;
  end

  // One clock of request. A quadrant strobe wins over a selection, and an
  // unused data bus toggles so that stale words cannot pass for fresh ones.
  task automatic drive(input logic s, input logic q, input mqwp_addr_t a,
                       input logic wn, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_sel   <= s & ~q & ~i_serial_config_done_n;
    o_quad  <= q;
    o_addr  <= a;
    o_wen_n <= wn;
    o_data  <= wn ? ~o_data : d;
  endtask : drive
endmodule : mqwp_writer

// >>> tb_multi_queue_write_port.sv
// Purpose: Self-checking bench for the multi-queue write port.
// Assumes: Device ID 5; direct flag mode until the polling test.
// Notes:   Outputs are read 1 ns after the edge that updates them.
`timescale 1ns/100ps
module tb_multi_queue_write_port;
  import mqwp_pkg::*;
  logic            clk, arst_n, cfg_n, sel, quad, wen_n, tok_in;
  mqwp_addr_t      addr;
  logic [35:0]     data, wr_d;
  mqwp_flag_mode_t mode;
  logic [31:0]     aful, full;
  logic            wr_v, own, sync, afl_n, ff_n, tok_out, peer;
  mqwp_queue_t     wr_q, cur;
  mqwp_quad_t      quadr;
  logic [7:0]      bus_n;
  int              mismatches, n_checks;

  mqwp_writer #(.DATA_W(36)) u_writer (.i_clk(clk),
    .i_serial_config_done_n(cfg_n), .o_addr(addr), .o_sel(sel),
    .o_quad(quad), .o_wen_n(wen_n), .o_data(data));

  mqwp_write_port #(.DATA_W(36)) dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_write_queue_select_strobe(sel), .i_write_queue_address(addr),
    .i_write_en_n(wen_n), .i_write_data(data),
    .i_flag_quadrant_strobe(quad), .i_flag_mode(mode),
    .i_device_id(3'h5), .i_queue_almost_full(aful), .i_queue_full(full),
    .i_expansion_token_in(tok_in), .o_wr_valid(wr_v), .o_wr_queue(wr_q),
    .o_wr_data(wr_d), .o_current_queue(cur), .o_device_owns_write(own),
    .o_almost_full_status_bus_n(bus_n), .o_status_frame_sync(sync),
    .o_quadrant(quadr), .o_almost_full_flag_n(afl_n),
    .o_full_flag_n(ff_n), .o_expansion_token_out(tok_out),
    .o_peer_token_seen(peer));

  // Free-running write clock; it is never gated.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare one value and count the outcome.
  task automatic chk(input string nm, input logic [35:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One writer cycle, then let the next edge's updates settle.
  task automatic step(input logic s, q, input mqwp_addr_t a,
                      input logic wn, input logic [35:0] d);
    u_writer.drive(s, q, a, wn, d);
    #1;
  endtask : step

  task automatic idle;
    step(1'b0, 1'b0, 8'h00, 1'b1, 36'h0);
  endtask : idle

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // The first clock edge applies reset even if the time-zero fall is missed.
  task automatic t_reset;
    @(posedge clk);
    #1;
    chk("valid", wr_v, 1'b0);
    chk("peer", peer, 1'b0);
    chk("queue", cur, 5'h00);
    chk("own", own, 1'b0);
    chk("full", ff_n, 1'b1);
    chk("status", bus_n, 8'hFF);
    $display("reset test done");
  endtask : t_reset

  // Selection with the write enable off; ownership and token follow.
  task automatic t_select;
    step(1'b1, 1'b0, 8'hA3, 1'b1, 36'h0);
    step(1'b0, 1'b0, 8'hA7, 1'b1, 36'h0);
    chk("queue", cur, 5'h00);
    idle();
    chk("queue", cur, 5'h03);
    chk("own", own, 1'b1);
    chk("token", tok_out, 1'b0);
    idle();
    chk("token", tok_out, 1'b1);
    chk("peer", peer, 1'b1);
    $display("select test done");
  endtask : t_select

  // Writes on the first four edges across a queue change, enable off on the fifth; ok says the new owner holds.
  task automatic run(input mqwp_addr_t a, input mqwp_queue_t qo, qn,
                     input logic ok);
    for (int k = 0; k < 5; k++) begin
      step(k == 0, 1'b0, (k == 0) ? a : 8'hA7, k == 4, 36'(k + 1));
      if (k > 0) begin
        chk("valid", wr_v, (k < 3) | ok);
        if (k < 3 || ok)
          chk("wqueue", wr_q, (k < 3) ? qo : qn);
        if (k < 3 || ok)
          chk("wdata", wr_d, 36'(k));
      end
    end
  endtask : run

  task automatic t_steer;
    run(8'hA9, 5'h03, 5'h09, 1'b1);
    chk("queue", cur, 5'h09);
    chk("afflag", afl_n, 1'b0);
    idle();
    chk("valid", wr_v, 1'b0);
    run(8'h2C, 5'h09, 5'h0C, 1'b0);
    chk("own", own, 1'b0);
    chk("queue", cur, 5'h0C);
    chk("fullflag", ff_n, 1'b0);
    chk("afflag", afl_n, 1'b1);
    $display("steer test done");
  endtask : t_steer

  // Quadrant strobe with don't-care middle bits, then a foreign one.
  task automatic t_quad;
    step(1'b0, 1'b1, 8'hBE, 1'b1, 36'h0);
    idle();
    chk("quadrant", quadr, 2'h2);
    idle();
    chk("status", bus_n, 8'(~aful[23:16]));
    step(1'b0, 1'b1, 8'h3D, 1'b1, 36'h0);
    idle();
    chk("quadrant", quadr, 2'h2);
    $display("quadrant test done");
  endtask : t_quad

  task automatic t_poll;
    @(posedge clk);
    mode <= MQWP_POLLED;
    for (int i = 0; i < 8 && sync !== 1'b1; i++)
      idle();
    for (int i = 0; i < 8; i++) begin
      chk("sync", sync, i % 4 == 0);
      chk("status", bus_n, 8'(~aful[8 * (i % 4) +: 8]));
      idle();
    end
    $display("polling test done");
  endtask : t_poll

  // Watchdog: the tests need under a hundred cycles.
  initial begin
    repeat (500) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence: reset for two cycles, then the scenarios in turn.
  initial begin
    arst_n     = 1'b0;
    cfg_n      = 1'b1;
    mode       = MQWP_DIRECT;
    tok_in     = 1'b0;
    aful       = 32'hA5C3_0F81;
    full       = 32'h0000_1000;
    mismatches = 0;
    n_checks   = 0;
    t_reset();
    repeat (1) @(posedge clk);
    arst_n <= 1'b1;
    cfg_n  <= 1'b0;
    tok_in <= 1'b1;
    t_select();
    t_steer();
    t_quad();
    t_poll();
    wrap_up();
  end
endmodule : tb_multi_queue_write_port
